// ===== shared/dma_cfg.svh
// Register offsets, field positions, reset values and timing counts of the DMA controller
`ifndef DMA_CFG_SVH
`define DMA_CFG_SVH

// Register byte offsets on the Wishbone bus
`define DMA_OFF_ARM 8'h00
`define DMA_OFF_REQ 8'h04
`define DMA_OFF_FLAG 8'h08
`define DMA_OFF_CTRL 8'h0c
`define DMA_OFF_CH_BASE 8'h20
`define DMA_OFF_CH_END 8'h70
`define DMA_CH_SUB_SRC 2'h0
`define DMA_CH_SUB_DST 2'h1
`define DMA_CH_SUB_CFG 2'h2

// Field positions
`define DMA_ARM_ABORT_BIT 7
`define DMA_CTRL_IEN_BIT 0
`define DMA_CTRL_FLAG_BIT 1
`define DMA_CFG_WIDTH 26

// Reset values
`define DMA_RST_CFG 26'h0000000
`define DMA_RST_PTR 16'h0000

// Length mode and transfer mode codes
`define DMA_LENGTH_MODE_FIELD_FIX0 3'h0
`define DMA_LENGTH_MODE_FIELD_P1 3'h1
`define DMA_LENGTH_MODE_FIELD_P0 3'h2
`define DMA_LENGTH_MODE_FIELD_P2 3'h3
`define DMA_LENGTH_MODE_FIELD_P3 3'h4
`define DMA_LENGTH_MODE_FIELD_FIX7 3'h7
`define DMA_TRANSFER_MODE_FIELD_SINGLE 2'h0
`define DMA_TRANSFER_MODE_FIELD_BLOCK 2'h1
`define DMA_TRANSFER_MODE_FIELD_RSINGLE 2'h2
`define DMA_TRANSFER_MODE_FIELD_RBLOCK 2'h3

// Configuration load time per armed channel, in system clocks
`define DMA_LOAD_CYCLES 4'd9

`endif

// ===== shared/dma_pkg.sv
// Types shared by the DMA controller modules
`default_nettype none
package dma_pkg;

	localparam int NCH = 5;

	// Engine states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_READ = 3'b010,
		ST_WRITE = 3'b100
	} eng_e;

	// Per-channel configuration word
	typedef struct packed {
		logic irq_sel;
		logic [4:0] trigger_selection_field_sel;
		logic [1:0] transfer_mode_field;
		logic word_sel;
		logic m8_sel;
		logic [2:0] length_mode_field;
		logic [12:0] max_len;
	} chan_cfg_s;

	// Whole state of the controller
	typedef struct packed {
		eng_e st;
		logic [2:0] ch;
		logic [15:0] data;
		logic wb_ack;
		logic [31:0] wb_dat;
		logic [NCH-1:0] armed;
		logic [NCH-1:0] ld_pend;
		logic ld_busy;
		logic [2:0] ld_ch;
		logic [3:0] ld_cnt;
		logic [NCH-1:0] man_req;
		logic [NCH-1:0] pend;
		logic [NCH-1:0] done_flag;
		logic sh_flag;
		logic sh_ien;
		logic irq;
		logic [15:0] mem_addr;
		logic [15:0] mem_wdata;
		logic mem_word;
		logic [NCH-1:0][15:0] sh_src;
		logic [NCH-1:0][15:0] sh_dst;
		logic [NCH-1:0][25:0] sh_cfg;
		chan_cfg_s [NCH-1:0] a_cfg;
		logic [NCH-1:0][15:0] a_src;
		logic [NCH-1:0][15:0] a_dst;
		logic [NCH-1:0][15:0] ptr_s;
		logic [NCH-1:0][15:0] ptr_d;
		logic [NCH-1:0][13:0] items;
		logic [NCH-1:0][13:0] total;
		logic [NCH-1:0] len_known;
	} dma_state_s;

endpackage : dma_pkg
`default_nettype wire

// ===== rtl/dma_trigger_selection_field_pick.sv
// Selects one channel's trigger event out of the event vector
`timescale 1ns/1ps
`default_nettype none
module dma_trigger_selection_field_pick
	import dma_pkg::*;
#(
	parameter int NEV = 31
)
(
	input wire logic [4:0] sel_i, // Selected trigger number
	input wire logic [NEV-1:0] ev_i, // Trigger event pulses
	output logic hit_o // Selected event seen
);

	// Trigger 0 means software request only, numbers past the table never fire
	always_comb
	begin
		hit_o = 1'b0;
		if (sel_i != 5'h00 && int'(sel_i) < NEV)
		begin
			hit_o = ev_i[sel_i];
		end
	end

endmodule : dma_trigger_selection_field_pick
`default_nettype wire

// ===== rtl/dma_ctrl.sv
// Five-channel DMA controller with Wishbone register slave and memory master port
//
// Notes on behaviour
// - five independent channels, zero through four.
// - only external data space addresses are reachable.
// - no transfer until channel arm bit set.
// - nine clocks load configuration after arming.
// - loading channel uses last trigger, reset zero.
// - nine clocks per channel, order 1..4 then 0.
// - one of 30 triggers per channel.
// - read from source, write to target pointer.
// - on count, disarm or rearm, set flag.
// - interrupt-select sets shared flag, gated interrupt.
// - length modes 000 and 111 use maximum length.
// - variable count n+1, n, n+2, n+3.
// - n from byte, seven bits, or thirteen bits.
// - n at or above maximum gives maximum.
// - eight-bit select ignored for word transfers.
// - each item is byte or word move.
// - single modes move one item per trigger.
// - block modes move whole count per trigger.
// - manual request flag triggers channel anytime; a request written to a disarmed channel is dropped.
// - abort bit with arm bits disarms channels.
//
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dma_cfg.svh"
module dma_ctrl
	import dma_pkg::*;
(
	input wire logic CLK_I, // System clock, 25 MHz
	input wire logic SRST_I, // Synchronous reset, active high
	input wire logic CYC_I, // Wishbone cycle
	input wire logic STB_I, // Wishbone strobe
	input wire logic WE_I, // Wishbone write enable
	input wire logic [7:0] ADR_I, // Wishbone byte address
	input wire logic [3:0] SEL_I, // Wishbone byte selects
	input wire logic [31:0] DAT_I, // Wishbone write data
	output logic [31:0] DAT_O, // Wishbone read data
	output logic ACK_O, // Wishbone acknowledge
	input wire logic [30:0] TRIGGER_SELECTION_FIELD_I, // Trigger event pulses, bit 0 unused
	output logic MEM_REQ_O, // Memory request, held until acknowledged
	output logic MEM_WE_O, // Memory write when high
	output logic MEM_WORD_O, // Word item when high, byte otherwise
	output logic [15:0] MEM_ADDR_O, // External data space address
	output logic [15:0] MEM_WDATA_O, // Memory write data
	input wire logic [15:0] MEM_RDATA_I, // Memory read data, valid with ack
	input wire logic MEM_ACK_I, // Memory acknowledge
	output logic IRQ_O // Interrupt request, level
);

	dma_state_s q, d;
	logic [NCH-1:0] hit;

	// One trigger selector per channel; loading keeps the previous selection active
	for (genvar g = 0; g < NCH; g++)
	begin : g_trigger_selection_field
		dma_trigger_selection_field_pick #(
			.NEV(31)
		) u_pick (
			.sel_i(q.a_cfg[g].trigger_selection_field_sel),
			.ev_i(TRIGGER_SELECTION_FIELD_I),
			.hit_o(hit[g])
		);
	end

	// Next loader channel: 1, 2, 3, 4, then 0 last
	function automatic logic [2:0] next_load(input logic [NCH-1:0] p);
		logic [2:0] r;
		r = 3'd0;
		if (p[1])
			r = 3'd1;
		else if (p[2])
			r = 3'd2;
		else if (p[3])
			r = 3'd3;
		else if (p[4])
			r = 3'd4;
		return r;
	endfunction : next_load

	// Transfer count from the first item and the length mode
	function automatic logic [13:0] var_count(input chan_cfg_s c, input logic [15:0] rd);
		logic [13:0] n;
		logic [13:0] k;
		n = 14'h0000;
		k = 14'h0000;
		if (c.word_sel)
			n = {1'b0, rd[12:0]};
		else if (c.m8_sel)
			n = {6'h00, rd[7:0]};
		else
			n = {7'h00, rd[6:0]};
		unique case (c.length_mode_field)
			`DMA_LENGTH_MODE_FIELD_P1: k = 14'h0001;
			`DMA_LENGTH_MODE_FIELD_P2: k = 14'h0002;
			`DMA_LENGTH_MODE_FIELD_P3: k = 14'h0003;
			default: k = 14'h0000;
		endcase
		if (n >= {1'b0, c.max_len})
			return {1'b0, c.max_len};
		return n + k;
	endfunction : var_count

	// Length modes outside 001..100 count the fixed maximum
	function automatic logic is_fixed(input logic [2:0] v);
		return (v == `DMA_LENGTH_MODE_FIELD_FIX0) || (v == `DMA_LENGTH_MODE_FIELD_FIX7) || (v > `DMA_LENGTH_MODE_FIELD_P3);
	endfunction : is_fixed

	// Whole controller next state
	always_comb
	begin
		logic [2:0] rch;
		logic [1:0] sub;
		logic bus_wr;
		logic bus_rd;
		logic [NCH-1:0] take;
		logic [13:0] cnt1;
		logic [15:0] step;
		chan_cfg_s c;
		logic sel_ok;
		d = q;
		rch = 3'd0;
		sub = 2'h0;
		take = '0;
		cnt1 = 14'h0000;
		step = 16'h0001;
		c = q.a_cfg[q.ch];
		sel_ok = 1'b0;
		bus_wr = CYC_I && STB_I && WE_I && !q.wb_ack;
		bus_rd = CYC_I && STB_I && !WE_I && !q.wb_ack;
		if (ADR_I >= `DMA_OFF_CH_BASE && ADR_I < `DMA_OFF_CH_END)
		begin
			rch = 3'((ADR_I - `DMA_OFF_CH_BASE) >> 4);
			sub = ADR_I[3:2];
			sel_ok = 1'b1;
		end

		// Wishbone answers one cycle after the strobe, every address acknowledged
		d.wb_ack = CYC_I && STB_I && !q.wb_ack;
		d.wb_dat = 32'h00000000;
		if (bus_rd)
		begin
			unique case (ADR_I)
				`DMA_OFF_ARM: d.wb_dat = {27'h0000000, q.armed};
				`DMA_OFF_REQ: d.wb_dat = {27'h0000000, q.man_req};
				`DMA_OFF_FLAG: d.wb_dat = {27'h0000000, q.done_flag};
				`DMA_OFF_CTRL: d.wb_dat = {30'h00000000, q.sh_flag, q.sh_ien};
				default:
				begin
					if (sel_ok && sub == `DMA_CH_SUB_SRC)
						d.wb_dat = {16'h0000, q.sh_src[rch]};
					else if (sel_ok && sub == `DMA_CH_SUB_DST)
						d.wb_dat = {16'h0000, q.sh_dst[rch]};
					else if (sel_ok && sub == `DMA_CH_SUB_CFG)
						d.wb_dat = {6'h00, q.sh_cfg[rch]};
				end
			endcase
		end

		// Software clears of flags come first so that hardware sets below win
		if (bus_wr && SEL_I[0])
		begin
			if (ADR_I == `DMA_OFF_FLAG)
				d.done_flag = q.done_flag & DAT_I[4:0];
			if (ADR_I == `DMA_OFF_CTRL)
			begin
				d.sh_ien = DAT_I[`DMA_CTRL_IEN_BIT];
				d.sh_flag = q.sh_flag & DAT_I[`DMA_CTRL_FLAG_BIT];
			end
			if (ADR_I == `DMA_OFF_REQ)
			begin
				d.man_req = q.man_req | (DAT_I[4:0] & q.armed);
			end
			if (ADR_I == `DMA_OFF_ARM)
			begin
				if (DAT_I[`DMA_ARM_ABORT_BIT])
				begin
					d.armed = q.armed & ~DAT_I[4:0];
					d.ld_pend = q.ld_pend & ~DAT_I[4:0];
					d.pend = q.pend & ~DAT_I[4:0];
					d.man_req = q.man_req & ~DAT_I[4:0];
				end
				else
				begin
					d.armed = q.armed | DAT_I[4:0];
					d.ld_pend = q.ld_pend | DAT_I[4:0];
				end
			end
		end
		// Configuration shadows accept full words only on their used lanes
		if (bus_wr && sel_ok)
		begin
			if (sub == `DMA_CH_SUB_SRC && SEL_I[1:0] == 2'b11)
				d.sh_src[rch] = DAT_I[15:0];
			if (sub == `DMA_CH_SUB_DST && SEL_I[1:0] == 2'b11)
				d.sh_dst[rch] = DAT_I[15:0];
			if (sub == `DMA_CH_SUB_CFG && SEL_I == 4'hf)
				d.sh_cfg[rch] = DAT_I[25:0];
		end

		// Trigger capture; disarmed channels forget events
		for (int i = 0; i < NCH; i++)
		begin
			if (q.armed[i] && (hit[i] || q.man_req[i]))
			begin
				take[i] = 1'b1;
				d.pend[i] = 1'b1;
				d.man_req[i] = bus_wr && SEL_I[0] && ADR_I == `DMA_OFF_REQ && DAT_I[i]; // New software set wins
			end
			if (!d.armed[i])
				d.pend[i] = 1'b0;
		end

		// Configuration loader, one channel at a time
		// serial load order
		if (!q.ld_busy && q.ld_pend != '0)
		begin
			d.ld_busy = 1'b1;
			d.ld_ch = next_load(q.ld_pend);
			d.ld_cnt = `DMA_LOAD_CYCLES - 4'd1;
		end
		else if (q.ld_busy)
		begin
			if (!d.ld_pend[q.ld_ch])
				d.ld_busy = 1'b0;
			else if (q.ld_cnt == 4'd1)
			begin
				d.ld_busy = 1'b0;
				d.ld_pend[q.ld_ch] = 1'b0;
				d.a_cfg[q.ld_ch] = chan_cfg_s'(q.sh_cfg[q.ld_ch]);
				d.a_src[q.ld_ch] = q.sh_src[q.ld_ch];
				d.a_dst[q.ld_ch] = q.sh_dst[q.ld_ch];
				d.ptr_s[q.ld_ch] = q.sh_src[q.ld_ch];
				d.ptr_d[q.ld_ch] = q.sh_dst[q.ld_ch];
				d.items[q.ld_ch] = 14'h0000;
				d.total[q.ld_ch] = {1'b0, q.sh_cfg[q.ld_ch][12:0]};
				d.len_known[q.ld_ch] = is_fixed(q.sh_cfg[q.ld_ch][15:13]);
			end
			else
				d.ld_cnt = q.ld_cnt - 4'd1;
		end

		// Transfer engine: read an item, then write it
		// item size from word select
		if (c.word_sel)
			step = 16'h0002;
		unique case (q.st)
			ST_IDLE:
			begin
				for (int i = NCH - 1; i >= 0; i--)
				begin
					if (q.pend[i] && q.armed[i])
					begin
						d.ch = 3'(i);
					end
				end
				if ((q.pend & q.armed) != '0)
				begin
					d.st = ST_READ;
					d.pend[d.ch] = take[d.ch];
					d.mem_addr = q.ptr_s[d.ch];
					d.mem_word = q.a_cfg[d.ch].word_sel;
				end
			end
			ST_READ:
			begin
				if (MEM_ACK_I)
				begin
					d.data = c.word_sel ? MEM_RDATA_I : {8'h00, MEM_RDATA_I[7:0]};
					if (!q.len_known[q.ch] && q.items[q.ch] == 14'h0000)
					begin
						d.total[q.ch] = var_count(c, MEM_RDATA_I);
						d.len_known[q.ch] = 1'b1;
					end
					d.mem_addr = q.ptr_d[q.ch];
					d.mem_wdata = c.word_sel ? MEM_RDATA_I : {8'h00, MEM_RDATA_I[7:0]};
					d.st = ST_WRITE;
				end
			end
			ST_WRITE:
			begin
				if (MEM_ACK_I)
				begin
					cnt1 = q.items[q.ch] + 14'h0001;
					d.items[q.ch] = cnt1;
					d.ptr_s[q.ch] = q.ptr_s[q.ch] + step;
					d.ptr_d[q.ch] = q.ptr_d[q.ch] + step;
					d.st = ST_IDLE;
					if (cnt1 >= q.total[q.ch])
					begin
						d.done_flag[q.ch] = 1'b1;
						if (c.irq_sel)
							d.sh_flag = 1'b1;
						if (c.transfer_mode_field == `DMA_TRANSFER_MODE_FIELD_RSINGLE || c.transfer_mode_field == `DMA_TRANSFER_MODE_FIELD_RBLOCK)
						begin
							d.ptr_s[q.ch] = q.a_src[q.ch];
							d.ptr_d[q.ch] = q.a_dst[q.ch];
							d.items[q.ch] = 14'h0000;
							d.total[q.ch] = {1'b0, c.max_len};
							d.len_known[q.ch] = is_fixed(c.length_mode_field);
						end
						else
						begin
							d.armed[q.ch] = 1'b0;
							d.pend[q.ch] = 1'b0;
							d.man_req[q.ch] = 1'b0;
						end
					end
					else if ((c.transfer_mode_field == `DMA_TRANSFER_MODE_FIELD_BLOCK || c.transfer_mode_field == `DMA_TRANSFER_MODE_FIELD_RBLOCK) && d.armed[q.ch])
					begin
						d.st = ST_READ;
						d.mem_addr = q.ptr_s[q.ch] + step;
					end
				end
			end
			default:
				d.st = ST_IDLE;
		endcase
		// An abort stops the engine once the bus item in flight is finished
		if (d.st == ST_READ && q.st == ST_WRITE && !d.armed[q.ch])
			d.st = ST_IDLE;

		d.irq = d.sh_flag && d.sh_ien;
	end

	// State register
	always_ff @(posedge CLK_I)
	begin
		if (SRST_I)
		begin
			q <= '0;
			q.st <= ST_IDLE;
		end
		else
			q <= d;
	end

	// Outputs; request and direction are handshake terms decoded from the state
	assign DAT_O = q.wb_dat;
	assign ACK_O = q.wb_ack;
	assign MEM_REQ_O = (q.st == ST_READ) || (q.st == ST_WRITE);
	assign MEM_WE_O = (q.st == ST_WRITE);
	assign MEM_WORD_O = q.mem_word;
	assign MEM_ADDR_O = q.mem_addr;
	assign MEM_WDATA_O = q.mem_wdata;
	assign IRQ_O = q.irq;

endmodule : dma_ctrl
`default_nettype wire

// ===== test/dma_ctrl_sva.sv
// Port checker for the DMA controller
`timescale 1ns/1ps
`default_nettype none
module dma_ctrl_sva (
	input wire logic CLK_I, // Clock
	input wire logic SRST_I, // Reset
	input wire logic CYC_I, // Cycle
	input wire logic STB_I, // Strobe
	input wire logic WE_I, // Bus write
	input wire logic [31:0] DAT_O, // Read data
	input wire logic ACK_O, // Bus ack
	input wire logic MEM_REQ_O, // Mem request
	input wire logic MEM_WE_O, // Mem write
	input wire logic MEM_WORD_O, // Word item
	input wire logic [15:0] MEM_ADDR_O, // Mem address
	input wire logic [15:0] MEM_WDATA_O, // Mem write data
	input wire logic [15:0] MEM_RDATA_I, // Mem read data
	input wire logic MEM_ACK_I, // Mem ack
	input wire logic IRQ_O // Interrupt
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (SRST_I);
	// Steps of a register access and of a memory item
	sequence wb_req;
		CYC_I && STB_I && !ACK_O;
	endsequence
	sequence rd_end;
		MEM_REQ_O && !MEM_WE_O && MEM_ACK_I;
	endsequence
	// Register access answers in exactly one cycle, for one cycle
	AST_ACK_NEXT: assert property (wb_req |=> ACK_O) else $error("ack missing");
	AST_ACK_DROP: assert property (ACK_O |=> !ACK_O) else $error("ack held");
	AST_DAT_IDLE: assert property (!ACK_O |-> DAT_O == 32'h0) else $error("read data not idle");
	// The write phase carries exactly what the read phase returned
	AST_WDATA: assert property (rd_end |=> MEM_REQ_O && MEM_WE_O
		&& MEM_WDATA_O == (MEM_WORD_O ? $past(MEM_RDATA_I) : ($past(MEM_RDATA_I) & 16'h00ff)))
		else $error("write data differs");
	AST_HOLD: assert property (MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && $stable(MEM_ADDR_O)
		&& $stable(MEM_WE_O) && $stable(MEM_WDATA_O)) else $error("request changed");
	AST_BYTE_HI: assert property (MEM_REQ_O && MEM_WE_O && !MEM_WORD_O |-> MEM_WDATA_O[15:8] == 8'h00)
		else $error("byte item upper half");
	// Interrupt follows a completion or a control write, and drops only on a write or a reset
	AST_IRQ_RISE: assert property ($rose(IRQ_O) |-> $past(MEM_ACK_I) || $past(MEM_ACK_I, 2)
		|| $past(WE_I) || $past(WE_I, 2)) else $error("spurious interrupt");
	AST_IRQ_FALL: assert property ($fell(IRQ_O) |-> $past(WE_I) || $past(WE_I, 2) || $past(SRST_I))
		else $error("interrupt lost");
endmodule : dma_ctrl_sva
bind dma_ctrl dma_ctrl_sva u_sva (.CLK_I(CLK_I), .SRST_I(SRST_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
	.DAT_O(DAT_O), .ACK_O(ACK_O), .MEM_REQ_O(MEM_REQ_O), .MEM_WE_O(MEM_WE_O), .MEM_WORD_O(MEM_WORD_O),
	.MEM_ADDR_O(MEM_ADDR_O), .MEM_WDATA_O(MEM_WDATA_O), .MEM_RDATA_I(MEM_RDATA_I), .MEM_ACK_I(MEM_ACK_I),
	.IRQ_O(IRQ_O));
`default_nettype wire

// ===== test/mem_model.sv
// Data space model on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module mem_model (
	input wire logic clk_i, // Clock
	input wire logic req_i, // Request
	input wire logic we_i, // Write phase
	input wire logic word_i, // Word item
	input wire logic [15:0] addr_i, // Address
	input wire logic [15:0] wdata_i, // Write data
	input wire logic [3:0] lat_i, // Wait cycles before ack
	output logic [15:0] rdata_o, // Read data
	output logic ack_o // Ack pulse
);
	logic [7:0] mem [0:255];
	logic [3:0] cnt;
	// Predictable fill; only the low address byte decodes, so keep traffic below 0x100
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h5a;
		cnt = 4'h0;
		ack_o = 1'b0;
		rdata_o = 16'h0;
	end
	// One ack per phase after lat_i cycles; read data toggles outside the ack cycle
	always @(posedge clk_i)
	begin
		rdata_o <= ~rdata_o;
		if (ack_o || !req_i)
		begin
			ack_o <= 1'b0;
			cnt <= 4'h0;
		end
		else if (cnt < lat_i)
			cnt <= cnt + 4'h1;
		else
		begin
			ack_o <= 1'b1;
			if (we_i)
			begin
				mem[addr_i[7:0]] <= wdata_i[7:0];
				if (word_i)
					mem[addr_i[7:0] + 8'h1] <= wdata_i[15:8];
			end
			else
				rdata_o <= {word_i ? mem[addr_i[7:0] + 8'h1] : 8'h00, mem[addr_i[7:0]]};
		end
	end
endmodule : mem_model
`default_nettype wire

// ===== test/five_channel_dma_controller_tb.sv
// Self-checking bench for the five-channel DMA controller
`timescale 1ns/1ps
`default_nettype none
`include "dma_cfg.svh"
module five_channel_dma_controller_tb
	import dma_pkg::*;
;
	logic clk, srst, cyc, stb, we, ack, mreq, mwe, mword, mack, irq;
	logic [7:0] adr;
	logic [31:0] wdat, rdat, q;
	logic [30:0] trigger_selection_field;
	logic [3:0] lat;
	logic [15:0] maddr, mwdata, mrdata;
	int num_errors, n_compared;
	dma_ctrl u_dut (.CLK_I(clk), .SRST_I(srst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hf),
		.DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .TRIGGER_SELECTION_FIELD_I(trigger_selection_field), .MEM_REQ_O(mreq), .MEM_WE_O(mwe),
		.MEM_WORD_O(mword), .MEM_ADDR_O(maddr), .MEM_WDATA_O(mwdata), .MEM_RDATA_I(mrdata), .MEM_ACK_I(mack),
		.IRQ_O(irq));
	mem_model u_mem (.clk_i(clk), .req_i(mreq), .we_i(mwe), .word_i(mword), .addr_i(maddr), .wdata_i(mwdata),
		.lat_i(lat), .rdata_o(mrdata), .ack_o(mack));
	// 25 MHz system clock
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task wrap_up;
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	task check(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : check
	// Classic cycle; waits for ack with a bound, hang ends the run
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1)
		begin
			num_errors++;
			wrap_up();
		end
	endtask : wb
	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		check(q, e);
	endtask : rd
	task setup(input logic [3:0] ch, input logic [15:0] s, input logic [15:0] d, input chan_cfg_s c);
		wr(8'h20 + {ch, 4'h0}, {16'h0, s});
		wr(8'h24 + {ch, 4'h0}, {16'h0, d});
		wr(8'h28 + {ch, 4'h0}, {6'h0, c});
	endtask : setup
	task wait_flag(input logic [4:0] m);
		int n;
		n = 0;
		do
		begin
			wb(1'b0, 8'h08, 32'h0);
			n++;
		end
		while ((q[4:0] & m) !== m && n < 100);
		if ((q[4:0] & m) !== m)
		begin
			num_errors++;
			wrap_up();
		end
	endtask : wait_flag
	// Arm, give the loader its time, then request by software
	task go(input logic [4:0] m, input logic [31:0] arm_exp);
		wr(8'h00, {27'h0, m});
		repeat (`DMA_LOAD_CYCLES + 2) @(posedge clk);
		wr(8'h04, {27'h0, m});
		wait_flag(m);
		rd(8'h04, 32'h0);
		rd(8'h00, arm_exp);
		wr(8'h08, 32'h0);
	endtask : go
	task pulse(input int k);
		@(posedge clk);
		trigger_selection_field <= 31'h1 << k;
		@(posedge clk);
		trigger_selection_field <= 31'h0;
		repeat (20) @(posedge clk);
	endtask : pulse
	task t_reset;
		rd(8'h00, 32'h0);
		rd(8'h08, 32'h0);
		rd(8'h0c, 32'h0);
		rd(8'h14, 32'h0);
		check(mreq, 1'b0);
		$display("reset test done");
	endtask : t_reset
	// Block move on channel 4; the count comes from the first item unless fixed
	task t_var(input logic [2:0] vl, input logic wd, input logic m8, input logic [15:0] first,
		input logic [12:0] len, input int cnt);
		int nb;
		logic [7:0] nxt;
		logic ir;
		logic [1:0] tm;
		nb = wd ? 2 * cnt : cnt;
		ir = (vl == `DMA_LENGTH_MODE_FIELD_FIX7);
		// The clipped n+3 case also exercises the repeated block mode
		tm = (vl == `DMA_LENGTH_MODE_FIELD_P3) ? `DMA_TRANSFER_MODE_FIELD_RBLOCK : `DMA_TRANSFER_MODE_FIELD_BLOCK;
		u_mem.mem[8'h30] = first[7:0];
		u_mem.mem[8'h31] = first[15:8];
		// Targets start as the inverse of the source, so a short or long move shows
		for (int i = 0; i < 24; i++)
			u_mem.mem[8'hb0 + i] = ~u_mem.mem[8'h30 + i];
		nxt = u_mem.mem[8'hb0 + nb];
		wr(8'h0c, 32'h1);
		setup(4'h4, 16'h0030, 16'h00b0, chan_cfg_s'{ir, 5'h00, tm, wd, m8, vl, len});
		go(5'h10, {27'h0, tm[1], 4'h0});
		for (int i = 0; i < nb; i++)
			check(u_mem.mem[8'hb0 + i], u_mem.mem[8'h30 + i]);
		check(u_mem.mem[8'hb0 + nb], nxt);
		check(irq, ir);
		rd(8'h0c, {30'h0, ir, 1'b1});
		wr(8'h0c, 32'h0);
		wr(8'h00, 32'h90);
		$display("length test done, %0d items", cnt);
	endtask : t_var
	// Repeated single on trigger 5; disarmed and foreign triggers move nothing
	task t_trigger_selection_field;
		logic [7:0] old;
		old = u_mem.mem[8'hd1];
		setup(4'h2, 16'h0050, 16'h00d0, chan_cfg_s'{1'b0, 5'h05, `DMA_TRANSFER_MODE_FIELD_RSINGLE, 1'b0, 1'b0, `DMA_LENGTH_MODE_FIELD_FIX0, 13'd2});
		pulse(5);
		wr(8'h00, 32'h0c);
		repeat (2 * `DMA_LOAD_CYCLES + 2) @(posedge clk);
		pulse(6);
		pulse(5);
		check(u_mem.mem[8'hd0], u_mem.mem[8'h50]);
		check(u_mem.mem[8'hd1], old);
		pulse(5);
		wait_flag(5'h04);
		check(u_mem.mem[8'hd1], u_mem.mem[8'h51]);
		rd(8'h00, 32'h0c);
		wr(8'h08, 32'h0);
		wr(8'h00, 32'h84);
		rd(8'h00, 32'h08);
		// A trigger seen while disarmed must not be served after rearming
		u_mem.mem[8'hd0] = ~u_mem.mem[8'h50];
		old = u_mem.mem[8'hd0];
		pulse(5);
		wr(8'h00, 32'h04);
		repeat (`DMA_LOAD_CYCLES + 2) @(posedge clk);
		check(u_mem.mem[8'hd0], old);
		wr(8'h00, 32'h8c);
		rd(8'h00, 32'h0);
		$display("trigger test done");
	endtask : t_trigger_selection_field
	// Main sequence
	initial
	begin
		srst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0;
		trigger_selection_field = 31'h0;
		lat = 4'h0;
		num_errors = 0;
		n_compared = 0;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_var(`DMA_LENGTH_MODE_FIELD_FIX7, 1'b0, 1'b0, 16'h00ff, 13'd3, 3);
		t_var(`DMA_LENGTH_MODE_FIELD_P1, 1'b0, 1'b1, 16'h0003, 13'd10, 4);
		lat <= 4'h2;
		t_var(`DMA_LENGTH_MODE_FIELD_P0, 1'b1, 1'b1, 16'he106, 13'd10, 10);
		t_var(`DMA_LENGTH_MODE_FIELD_P2, 1'b0, 1'b0, 16'h0083, 13'd10, 5);
		t_var(`DMA_LENGTH_MODE_FIELD_P3, 1'b0, 1'b1, 16'h00f0, 13'd7, 7);
		t_trigger_selection_field();
		wrap_up();
	end
endmodule : five_channel_dma_controller_tb
`default_nettype wire
